// [common/emr_defines.svh]
`ifndef EMR_DEFINES_SVH
`define EMR_DEFINES_SVH
// address and bank widths
`define EMR_ADDR_W 13
`define EMR_BANK_W 2
// extended register field positions
`define EMR_DLL_BIT 0
`define EMR_DRV_BIT 1
`define EMR_FET_BIT 2
`define EMR_OPM_LO 3
// bank code of an extended load
`define EMR_BANK_EXT 2'h1
// bank code of a base mode load
`define EMR_BANK_BASE 2'h0
// reset values of the device copy
`define EMR_RST_VAL 13'h0000
// dll lock wait, cycles
`define EMR_DLL_LOCK_CYC 200
// mode-set occupancy, cycles
`define EMR_MRD_CYC 2
// apb register byte offsets (controller)
`define EMR_OFF_CTRL 12'h000
`define EMR_OFF_DATA 12'h004
`define EMR_OFF_STAT 12'h008
`define EMR_OFF_BANK 12'h00c
// ctrl and status bits
`define EMR_CTRL_GO 0
`define EMR_CTRL_CKE 1
`define EMR_STAT_BUSY 0
`define EMR_STAT_IDLE 1
// wait counter width
`define EMR_CNT_W 8
`endif

// [common/emr_pkg.sv]
`default_nettype none
package emr_pkg;
    typedef logic [12:0] emr_addr_t;
    typedef logic [1:0] emr_bank_t;
    // controller sequencer states
    typedef enum logic [3:0] {
        EMR_ST_IDLE = 4'h1,
        EMR_ST_ISSUE = 4'h2,
        EMR_ST_HOLD = 4'h4,
        EMR_ST_LOCK = 4'h8
    } emr_state_e;
endpackage : emr_pkg
`default_nettype wire

// [common/emr_cmd_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface emr_cmd_if;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] bank;
    logic [12:0] addr;
    modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, bank, addr);
    modport dev (input cke, cs_n, ras_n, cas_n, we_n, bank, addr);
endinterface : emr_cmd_if
`default_nettype wire

// [logic/emr_device.sv]
`timescale 1ns/10ps
`default_nettype none
`include "emr_defines.svh"
module emr_device
    import emr_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // command bus
    emr_cmd_if.dev cmd,
    // decoded extended settings
    output logic dll_disable,
    output logic drive_strength_select,
    output logic fet_switch_control,
    output logic [`EMR_ADDR_W-1:0] ext_mode_q_out,
    output logic mode_normal
);
    // ****************************************
    // extended register
    // ****************************************
    emr_addr_t ext_q;
    emr_addr_t ext_d;
    logic load_cmd;
    assign load_cmd = cmd.cke & ~cmd.cs_n & ~cmd.ras_n & ~cmd.cas_n
        & ~cmd.we_n;
    always_comb begin
        ext_d = ext_q;
        if (load_cmd && cmd.bank == `EMR_BANK_EXT) begin
            ext_d = cmd.addr;
        end
    end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ext_q <= `EMR_RST_VAL;
        end else begin
            ext_q <= ext_d;
        end
    end
    assign dll_disable = ext_q[`EMR_DLL_BIT];
    assign drive_strength_select = ext_q[`EMR_DRV_BIT];
    assign fet_switch_control = ext_q[`EMR_FET_BIT];
    assign ext_mode_q_out = ext_q;
    assign mode_normal = ~|ext_q[`EMR_ADDR_W-1:`EMR_OPM_LO];
endmodule : emr_device
`default_nettype wire

// [logic/emr_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
`include "emr_defines.svh"
module emr_ctrl
    import emr_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // bank state from core logic
    input wire logic banks_idle,
    // command bus
    emr_cmd_if.ctrl cmd
);
    // ****************************************
    // registers and sequencer
    // ****************************************
    emr_state_e st_q, st_d;
    logic [1:0] dat_q, dat_d;
    logic cke_q, cke_d;
    logic cke_seen_q, cke_seen_d;
    logic go_q, go_d;
    logic [`EMR_CNT_W-1:0] cnt_q, cnt_d;
    logic [31:0] rd_d, rd_q;
    logic cs_n_q, cs_n_d;
    emr_addr_t addr_q, addr_d;
    logic wr, rd, go_wr;
    assign wr = psel & penable & pwrite;
    // read data latched in setup phase
    assign rd = psel & ~penable & ~pwrite;
    assign go_wr = wr & (paddr == `EMR_OFF_CTRL) & pwdata[`EMR_CTRL_GO];
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    always_comb begin
        st_d = st_q;
        dat_d = dat_q;
        cke_d = cke_q;
        go_d = go_q;
        cnt_d = cnt_q;
        cs_n_d = 1'b1;
        addr_d = addr_q;
        cke_seen_d = cke_q;
        rd_d = rd_q;
        if (wr && paddr == `EMR_OFF_CTRL) begin
            go_d = pwdata[`EMR_CTRL_GO] | go_q;
            cke_d = pwdata[`EMR_CTRL_CKE];
        end else if (wr && paddr == `EMR_OFF_DATA) begin
            dat_d = pwdata[1:0];
        end
        if (rd) begin
            rd_d = 32'h0;
        end
        if (rd && paddr == `EMR_OFF_CTRL) begin
            rd_d = {30'h0, cke_q, go_q};
        end else if (rd && paddr == `EMR_OFF_DATA) begin
            rd_d = {30'h0, dat_q};
        end else if (rd && paddr == `EMR_OFF_STAT) begin
            rd_d = {30'h0, banks_idle, st_q != EMR_ST_IDLE};
        end else if (rd && paddr == `EMR_OFF_BANK) begin
            rd_d = {30'h0, `EMR_BANK_EXT};
        end
        case (st_q)
            EMR_ST_IDLE: begin
                if (go_q && banks_idle && cke_q && cke_seen_q) begin
                    st_d = EMR_ST_ISSUE;
                end
            end
            EMR_ST_ISSUE: begin
                cs_n_d = 1'b0;
                addr_d = {11'h0, dat_q};
                // new go request wins over self clear
                if (!go_wr) begin
                    go_d = 1'b0;
                end
                cnt_d = `EMR_CNT_W'(`EMR_MRD_CYC - 1);
                st_d = EMR_ST_HOLD;
            end
            EMR_ST_HOLD: begin
                if (cnt_q == '0) begin
                    if (!addr_q[`EMR_DLL_BIT]) begin
                        cnt_d = `EMR_CNT_W'(`EMR_DLL_LOCK_CYC - 1);
                        st_d = EMR_ST_LOCK;
                    end else begin
                        st_d = EMR_ST_IDLE;
                    end
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            EMR_ST_LOCK: begin
                if (cnt_q == '0) begin
                    st_d = EMR_ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            default: begin
                st_d = EMR_ST_IDLE;
            end
        endcase
    end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= EMR_ST_IDLE;
            dat_q <= 2'h0;
            cke_q <= 1'b0;
            cke_seen_q <= 1'b0;
            go_q <= 1'b0;
            cnt_q <= '0;
            cs_n_q <= 1'b1;
            addr_q <= `EMR_RST_VAL;
            rd_q <= 32'h0;
        end else begin
            st_q <= st_d;
            dat_q <= dat_d;
            cke_q <= cke_d;
            cke_seen_q <= cke_seen_d;
            go_q <= go_d;
            cnt_q <= cnt_d;
            cs_n_q <= cs_n_d;
            addr_q <= addr_d;
            rd_q <= rd_d;
        end
    end
    // ****************************************
    // command drive
    // ****************************************
    assign prdata = rd_q;
    assign cmd.cke = cke_q;
    assign cmd.cs_n = cs_n_q;
    assign cmd.ras_n = cs_n_q;
    assign cmd.cas_n = cs_n_q;
    assign cmd.we_n = cs_n_q;
    assign cmd.bank = `EMR_BANK_EXT;
    assign cmd.addr = addr_q;
endmodule : emr_ctrl
`default_nettype wire

// [test/emr_properties.sv]
`timescale 1ns/10ps
`default_nettype none
`include "emr_defines.svh"
module emr_properties (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // command bus
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] bank,
    input wire logic [12:0] addr,
    // decoded settings
    input wire logic dll_disable,
    input wire logic drive_strength_select
);
    // ****
    // load decode
    // ****
    logic ld;
    assign ld = cke & ~cs_n & ~ras_n & ~cas_n & ~we_n;
    // ****
    // dll lock gap
    // ****
    logic [`EMR_CNT_W-1:0] lock_cnt_q;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            lock_cnt_q <= '0;
        end else if (ld && !addr[`EMR_DLL_BIT]) begin
            lock_cnt_q <= `EMR_CNT_W'(`EMR_DLL_LOCK_CYC);
        end else if (lock_cnt_q != '0) begin
            lock_cnt_q <= lock_cnt_q - 1'b1;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    sequence quiet_s;
        (ras_n && cas_n && we_n) [*2];
    endsequence
    ext_bank_a: assert property (ld |-> bank == 2'h1)
        else $error("load with wrong bank code");
    keep_word_a: assert property (!ld |=> $stable(dll_disable)
        && $stable(drive_strength_select))
        else $error("settings changed without load");
    dll_load_a: assert property (ld |=> dll_disable == $past(addr[0]))
        else $error("dll setting not loaded");
    drive_load_a: assert property (ld |=>
        drive_strength_select == $past(addr[1]))
        else $error("drive setting not loaded");
    fet_zero_a: assert property (ld |-> !addr[2])
        else $error("fet bit not zero");
    opmode_zero_a: assert property (ld |-> addr[12:3] == 10'h000)
        else $error("operating mode not zero");
    load_quiet_a: assert property (ld |=> quiet_s)
        else $error("command during load");
    cke_first_a: assert property (ld |-> $past(cke))
        else $error("load without clock enable before");
    lock_gap_a: assert property (ld |-> lock_cnt_q == '0)
        else $error("load inside dll lock wait");
endmodule : emr_properties
`default_nettype wire

// [test/test_ddr_extended_mode_register.sv]
`timescale 1ns/10ps
`default_nettype none
module test_ddr_extended_mode_register;
    logic core_clk = 0;
    logic arst_n = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic banks_idle = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, dll_disable, drive_strength_select;
    logic fet_switch_control, mode_normal;
    logic err;
    logic [12:0] ext_mode_q_out;
    int fails = 0;
    int compares = 0;
    int n;
    emr_cmd_if cmd_bus ();
    emr_ctrl emr_ctrl_i (.core_clk, .arst_n, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .banks_idle,
        .cmd(cmd_bus));
    emr_device emr_device_i (.core_clk, .arst_n, .cmd(cmd_bus), .dll_disable,
        .drive_strength_select, .fet_switch_control, .ext_mode_q_out,
        .mode_normal);
    emr_properties emr_properties_i (.core_clk, .arst_n, .cke(cmd_bus.cke),
        .cs_n(cmd_bus.cs_n), .ras_n(cmd_bus.ras_n), .cas_n(cmd_bus.cas_n),
        .we_n(cmd_bus.we_n), .bank(cmd_bus.bank), .addr(cmd_bus.addr),
        .dll_disable, .drive_strength_select);
    always #2 core_clk = ~core_clk;
    // ****
    // apb access and checks
    // ****
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task wait_idle;
        n = 0;
        rd = 32'h1;
        while (rd[0] !== 1'b0 && n < 3000) begin
            apb(1'b0, 12'h008, 32'h0);
            n += 3;
        end
        chk("idle", 32'h0, {31'h0, rd[0]});
    endtask : wait_idle
    task report_and_stop;
        if (fails == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : report_and_stop
    initial begin
        #100000;
        fails++;
        report_and_stop();
    end
    initial begin
        repeat (5) @(posedge core_clk);
        arst_n <= 1'b1;
        apb(1'b0, 12'h00c, 32'h0);
        chk("bank code", 32'h1, rd);
        chk("slave error", 32'h0, {31'h0, err});
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped read", 32'h0, rd);
        chk("reset word", 32'h0, {19'h0, ext_mode_q_out});
        apb(1'b1, 12'h000, 32'h2);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl readback", 32'h2, rd);
        apb(1'b1, 12'h004, 32'h3);
        apb(1'b0, 12'h004, 32'h0);
        chk("data readback", 32'h3, rd);
        apb(1'b0, 12'h008, 32'h0);
        chk("status busy banks", 32'h0, rd);
        apb(1'b1, 12'h000, 32'h3);
        repeat (20) @(posedge core_clk);
        chk("load with busy banks", 32'h0, {19'h0, ext_mode_q_out});
        banks_idle <= 1'b1;
        wait_idle();
        apb(1'b0, 12'h008, 32'h0);
        chk("status idle banks", 32'h2, rd);
        for (int i = 3; i >= 0; i--) begin
            apb(1'b1, 12'h004, 32'(i));
            apb(1'b1, 12'h000, 32'h3);
            wait_idle();
            chk("word", 32'(i), {19'h0, ext_mode_q_out});
            chk("dll", 32'(i & 1), {31'h0, dll_disable});
            chk("drive", 32'(i / 2), {31'h0, drive_strength_select});
            chk("fet", 32'h0, {31'h0, fet_switch_control});
            chk("normal", 32'h1, {31'h0, mode_normal});
            chk("lock wait", 32'(~i & 1), 32'(n >= 200));
        end
        apb(1'b1, 12'h004, 32'h3);
        repeat (10) @(posedge core_clk);
        chk("word kept", 32'h0, {19'h0, ext_mode_q_out});
        report_and_stop();
    end
endmodule : test_ddr_extended_mode_register
`default_nettype wire
